//--- hdl/fps_ctrl.v
// flash programming and security controller: apb registers, operation sequencer,
// baud measurement for the serial programming link and interrupt status
// assumes apb master on clk_in, irq flags and masks synchronous to clk_in
`timescale 1ns/1ns
`include "fps_defines.vh"
module fps_ctrl #(
  parameter OP_CYCLES = `FPS_OP_CYCLES,
  parameter BAUD_W = 16
) (
  // clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // programming pins and link
  input wire flash_mode_pin_in,
  input wire prog_rx_in,
  // processor interrupt flags and masks (32 sources, one bit each)
  input wire [31:0] irq_request_flags_in,
  input wire [31:0] irq_mask_flags_in,
  // flash array strobes and address, serial link clock enable
  output reg flash_erase_out,
  output reg flash_write_out,
  output reg [15:0] flash_addr_out,
  output reg link_clk_en_out,
  // interrupt
  output wire irq_out
);
  // sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_BUSY = 2'h1;
  // baud measurement states; a separate machine, so the codes may overlap
  localparam ST_WAIT_PULSE = 2'h0;
  localparam ST_WAIT_CMD = 2'h1;
  localparam ST_MEASURE = 2'h2;
  localparam ST_LOCKED = 2'h3;

  // decodes a bus write to one register offset
  function wr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = psel_in & penable_in & pwrite_in & (addr == ofs);
    end
  endfunction

  // command decodes shared by the security check and the strobe setup;
  // true for the three codes that the sequencer knows
  function cmd_known;
    input [2:0] cmd;
    begin
      cmd_known = (cmd == `FPS_CMD_ERASE) || (cmd == `FPS_CMD_WRITE) || (cmd == `FPS_CMD_EPV);
    end
  endfunction

  // true for commands that erase cells, which batch protection forbids
  function cmd_erases;
    input [2:0] cmd;
    begin
      cmd_erases = (cmd == `FPS_CMD_ERASE) || (cmd == `FPS_CMD_EPV);
    end
  endfunction

  // true for commands that program cells
  function cmd_writes;
    input [2:0] cmd;
    begin
      cmd_writes = (cmd == `FPS_CMD_WRITE) || (cmd == `FPS_CMD_EPV);
    end
  endfunction

  // software-visible registers
  reg [6:0] ctrl_q;
  reg [1:0] sec_q;
  reg [3:0] ist_q;
  reg [3:0] imask_q;
  reg [15:0] addr_q;
  reg [31:0] prdata_q;

  // operation sequencer
  reg [1:0] st_q;
  reg [31:0] cnt_q;
  reg aborted_q;
  reg refused_q;

  // baud measurement and pin samples
  reg [1:0] bst_q;
  reg [BAUD_W-1:0] baud_q;
  reg [BAUD_W-1:0] bcnt_q;
  reg [1:0] pulse_q;
  reg fmp_q;
  reg rx_q;

  // combinational decodes
  reg [31:0] rdata_d;
  reg [3:0] ev_d;
  reg start_ok;
  reg refuse;
  wire [2:0] cmd_w;
  wire start_w;
  wire clk_ok;
  wire irq_any;
  wire irq_unmasked;
  wire irq_pend;

  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign cmd_w = pwdata_in[`FPS_CTRL_CMD_LSB+2:`FPS_CTRL_CMD_LSB];
  assign start_w = wr_hit(paddr_in, `FPS_CTRL_OFS) & pwdata_in[`FPS_CTRL_START_BIT];
  // only crystal or external main clock may drive the serial link
  assign clk_ok = (ctrl_q[5:4] == `FPS_CLK_CRYSTAL) | (ctrl_q[5:4] == `FPS_CLK_EXTMAIN);
  // any raised request flag stops self-programming, masked or not
  assign irq_any = |irq_request_flags_in;
  // an unmasked request stops it as well, whatever the processor's disable state;
  // with every flag checked this term adds nothing, but it keeps the rule visible
  assign irq_unmasked = |(irq_request_flags_in & ~irq_mask_flags_in);
  assign irq_pend = irq_any | irq_unmasked;
  // the interrupt line is a plain level, so software sees it in the same cycle
  assign irq_out = |(ist_q & imask_q);
  // read data comes from a flop loaded in the setup cycle
  assign prdata_out = prdata_q;

  // decide whether a requested command is allowed by the security settings
  always @*
  begin
    refuse = 1'b0;
    // the erase check assigns refuse outright and must stay first; the later checks only raise it
    if (cmd_erases(cmd_w))
      refuse = sec_q[`FPS_SEC_BATCH_BIT];
    if ((cmd_w == `FPS_CMD_WRITE) && sec_q[`FPS_SEC_BATCH_BIT] && !(&pwdata_in[31:16]))
      refuse = 1'b1; // blank-only writes survive
    if ((cmd_w != 3'h0) && sec_q[`FPS_SEC_BOOT0_BIT] && (addr_q < `FPS_BOOT0_LIMIT))
      refuse = 1'b1;
    if (!flash_mode_pin_in || !cmd_known(cmd_w))
      refuse = 1'b1; // mode pin low means no self-programming
    // a pending request does not refuse; it aborts, so software can retry
    start_ok = start_w & (st_q == ST_IDLE) & ~refuse & ~irq_pend;
  end

  // read mux; unmapped offsets read as zero
  // and writes to them are dropped without an error response
  always @*
  begin
    rdata_d = 32'h0000_0000;
    case (paddr_in)
      `FPS_CTRL_OFS: rdata_d = {25'h000_0000, ctrl_q};
      `FPS_STAT_OFS: rdata_d = {26'h000_0000, refused_q, aborted_q, bst_q, st_q};
      `FPS_IRQ_STAT_OFS: rdata_d = {28'h000_0000, ist_q};
      `FPS_IRQ_MASK_OFS: rdata_d = {28'h000_0000, imask_q};
      `FPS_SECURITY_OFS: rdata_d = {30'h0000_0000, sec_q};
      `FPS_ADDR_OFS: rdata_d = {16'h0000, addr_q};
      `FPS_BAUD_OFS: rdata_d = {{(32-BAUD_W){1'b0}}, baud_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // read data flop: loaded on the setup edge, it stands through the access cycle;
  // the price is that a read shows the state one cycle before the access edge
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prdata_q <= 32'h0000_0000;
    else if (psel_in && !penable_in)
      prdata_q <= rdata_d;
  end

  // software registers; security bits are sticky until reset
  // the start bit is not stored: it acts only in the cycle of the write
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl_q <= 7'h00;
      sec_q <= 2'h0;
      imask_q <= 4'h0;
      addr_q <= 16'h0000;
    end
    else
    begin
      if (wr_hit(paddr_in, `FPS_CTRL_OFS))
        ctrl_q <= {pwdata_in[6:1], 1'b0};
      if (wr_hit(paddr_in, `FPS_SECURITY_OFS))
        sec_q <= sec_q | pwdata_in[1:0]; // once applied, cannot be lifted
      if (wr_hit(paddr_in, `FPS_IRQ_MASK_OFS))
        imask_q <= pwdata_in[3:0];
      if (wr_hit(paddr_in, `FPS_ADDR_OFS))
        addr_q <= pwdata_in[15:0];
    end
  end

  // operation sequencer
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 32'h0000_0000;
      aborted_q <= 1'b0;
      refused_q <= 1'b0;
      flash_erase_out <= 1'b0;
      flash_write_out <= 1'b0;
      flash_addr_out <= 16'h0000;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (start_ok)
          begin
            // the address is latched here, so a later write to the address register
            // cannot move an operation that is already running
            st_q <= ST_BUSY;
            cnt_q <= 32'h0000_0000;
            aborted_q <= 1'b0;
            refused_q <= 1'b0;
            flash_addr_out <= addr_q;
            flash_erase_out <= cmd_erases(cmd_w);
            flash_write_out <= cmd_writes(cmd_w);
          end
          else if (start_w)
          begin
            refused_q <= refuse;
            aborted_q <= ~refuse; // blocked by a pending request
          end
        end
        ST_BUSY:
        begin
          // a request cuts the operation short: both strobes drop on the next edge,
          // and the cells touched so far are left in an unknown state
          if (irq_pend)
          begin
            st_q <= ST_IDLE;
            aborted_q <= 1'b1;
            flash_erase_out <= 1'b0;
            flash_write_out <= 1'b0;
          end
          // last cycle: the done event fires on this same edge
          else if (cnt_q == OP_CYCLES - 1)
          begin
            st_q <= ST_IDLE;
            flash_erase_out <= 1'b0;
            flash_write_out <= 1'b0;
          end
          else
            cnt_q <= cnt_q + 32'h0000_0001;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // events for the interrupt status
  always @*
  begin
    ev_d = 4'h0;
    ev_d[`FPS_EV_DONE] = (st_q == ST_BUSY) & ~irq_pend & (cnt_q == OP_CYCLES - 1);
    ev_d[`FPS_EV_REFUSED] = start_w & (st_q == ST_IDLE) & refuse;
    ev_d[`FPS_EV_ABORT] = ((st_q == ST_BUSY) & irq_pend) | (start_w & (st_q == ST_IDLE) & ~refuse & irq_pend);
    // the lock event needs the same enable as the capture, or a mode change in
    // mid-measurement would report a lock that never stored a count
    ev_d[`FPS_EV_BAUD] = (bst_q == ST_MEASURE) & rx_q & prog_rx_in & ctrl_q[`FPS_CTRL_UART_BIT] & clk_ok;
  end

  // sticky status, write one to clear; a new event wins over the clear, so an
  // event that lands on the clearing write is never lost
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ist_q <= 4'h0;
    else if (wr_hit(paddr_in, `FPS_IRQ_STAT_OFS))
      ist_q <= (ist_q & ~pwdata_in[3:0]) | ev_d;
    else
      ist_q <= ist_q | ev_d;
  end

  // baud measurement: mode pulses on the mode pin, then the low start bit of
  // the reset command is timed; the count is the bit period in clocks
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bst_q <= ST_WAIT_PULSE;
      baud_q <= {BAUD_W{1'b0}};
      bcnt_q <= {BAUD_W{1'b0}};
      pulse_q <= 2'h0;
      // match the idle-high pin, so the first sample cannot look like an edge
      fmp_q <= 1'b1;
      rx_q <= 1'b1;
      link_clk_en_out <= 1'b0;
    end
    else
    begin
      fmp_q <= flash_mode_pin_in;
      rx_q <= prog_rx_in;
      link_clk_en_out <= ctrl_q[`FPS_CTRL_UART_BIT] & clk_ok;
      // leaving uart mode or choosing a bad clock restarts the search for pulses
      if (!ctrl_q[`FPS_CTRL_UART_BIT] || !clk_ok)
      begin
        bst_q <= ST_WAIT_PULSE;
        pulse_q <= 2'h0;
      end
      else
      begin
        case (bst_q)
          ST_WAIT_PULSE:
          begin
            // the reset command only counts after the mode pulses
            if (fmp_q && !flash_mode_pin_in)
              pulse_q <= pulse_q + 2'h1;
            if (pulse_q != 2'h0 && flash_mode_pin_in)
              bst_q <= ST_WAIT_CMD;
          end
          ST_WAIT_CMD:
          begin
            if (rx_q && !prog_rx_in)
            begin
              bst_q <= ST_MEASURE;
              bcnt_q <= {BAUD_W{1'b0}};
            end
          end
          ST_MEASURE:
          begin
            if (rx_q && prog_rx_in)
            begin
              baud_q <= bcnt_q;
              bst_q <= ST_LOCKED;
            end
            // saturate, so a line stuck low cannot wrap round to a short period
            else if (!(&bcnt_q))
              bcnt_q <= bcnt_q + {{(BAUD_W-1){1'b0}}, 1'b1};
          end
          default: bst_q <= ST_LOCKED;
        endcase
      end
    end
  end
endmodule

//--- hdl/fps_defines.vh
// constants for the flash programming and security controller
// assumes a 10 MHz system clock and a 32-bit apb register bus
// Behaviour
// - uart programming link runs only from crystal or external main clock
// - receive baud clock is measured from the reset command after mode pulses
// - after batch-erase protection is set, every erase request is rejected
// - with batch-erase protection, writes cannot change programmed data
// - boot-cluster protection refuses any rewrite of boot cluster 0
// - any pending interrupt request stops self-programming at once
// - an unmasked request aborts self-programming even with interrupts disabled
`ifndef FPS_DEFINES_VH
`define FPS_DEFINES_VH
// register byte offsets
`define FPS_CTRL_OFS 8'h00
`define FPS_STAT_OFS 8'h04
`define FPS_IRQ_STAT_OFS 8'h08
`define FPS_IRQ_MASK_OFS 8'h0C
`define FPS_SECURITY_OFS 8'h10
`define FPS_ADDR_OFS 8'h14
`define FPS_BAUD_OFS 8'h18
// ctrl fields
`define FPS_CTRL_START_BIT 0
`define FPS_CTRL_CMD_LSB 1
`define FPS_CTRL_CLKSEL_LSB 4
`define FPS_CTRL_UART_BIT 6
// commands
`define FPS_CMD_ERASE 3'h1
`define FPS_CMD_WRITE 3'h2
`define FPS_CMD_EPV 3'h3
// clock sources
`define FPS_CLK_INTERNAL 2'h0
`define FPS_CLK_CRYSTAL 2'h1
`define FPS_CLK_EXTMAIN 2'h2
// security bits
`define FPS_SEC_BATCH_BIT 0
`define FPS_SEC_BOOT0_BIT 1
// event bits in irq status
`define FPS_EV_DONE 0
`define FPS_EV_REFUSED 1
`define FPS_EV_ABORT 2
`define FPS_EV_BAUD 3
// timing: one flash operation in ns and in cycles at 100 ns period
`define FPS_OP_TIME_NS 3200
`define FPS_CLK_PERIOD_NS 100
`define FPS_OP_CYCLES (`FPS_OP_TIME_NS / `FPS_CLK_PERIOD_NS)
// boot cluster 0 occupies addresses below this word address
`define FPS_BOOT0_LIMIT 16'h1000
`endif

//--- test/fps_ctrl_chk.sv
// assertions on the ports of fps_ctrl, bound into every instance
// assumes one clock domain, async active-low reset, apb writes on psel&penable
`timescale 1ns/1ns
module fps_ctrl_chk #(parameter OP_CYCLES = 32) (
  // clock and reset
  input wire clk_in,
  input wire arst_n_in,
  // apb
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire pready_out,
  input wire pslverr_out,
  // pins and flags
  input wire flash_mode_pin_in,
  input wire [31:0] irq_request_flags_in,
  // results
  input wire flash_erase_out,
  input wire flash_write_out,
  input wire [15:0] flash_addr_out,
  input wire link_clk_en_out,
  input wire irq_out
);
  wire wr_c = psel_in && penable_in && pwrite_in;
  wire run = flash_erase_out || flash_write_out;
  reg [6:0] ctl_q;
  reg [1:0] sec_q;
  reg [3:0] msk_q;
  reg [7:0] cnt_q;
  wire lnk_ok = ctl_q[6] && (ctl_q[5:4] == 2'h1 || ctl_q[5:4] == 2'h2);
  // shadow of software settings; strobe counter avoids a long repetition
  always @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      ctl_q <= 7'h00;
      sec_q <= 2'h0;
      msk_q <= 4'h0;
      cnt_q <= 8'h00;
    end
    else
    begin
      if (wr_c && paddr_in == 8'h00) ctl_q <= pwdata_in[6:0];
      if (wr_c && paddr_in == 8'h10) sec_q <= sec_q | pwdata_in[1:0];
      if (wr_c && paddr_in == 8'h0C) msk_q <= pwdata_in[3:0];
      cnt_q <= run ? cnt_q + 8'h01 : 8'h00;
    end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_start;
    $rose(run);
  endsequence
  // two cycles of a bad setting, since the enable is registered
  sequence s_bad_lnk;
    !lnk_ok ##1 !lnk_ok;
  endsequence
  chk_apb_answer: assert property (pready_out && !pslverr_out) else $error("apb answer wrong");
  chk_link_src: assert property (s_bad_lnk |-> !link_clk_en_out)
    else $error("link clock on from bad source");
  chk_pin_start: assert property (s_start |-> $past(flash_mode_pin_in))
    else $error("start with mode pin low");
  chk_pend_start: assert property (s_start |-> $past(irq_request_flags_in) == 32'h0)
    else $error("start with request pending");
  chk_abort_stop: assert property (run && irq_request_flags_in != 32'h0 |=> !run)
    else $error("strobes stay after request");
  chk_batch_erase: assert property (s_start |-> !(flash_erase_out && $past(sec_q[0])))
    else $error("erase under protection");
  chk_batch_write: assert property (s_start and $past(sec_q[0]) |-> $past(pwdata_in[31:16]) == 16'hFFFF)
    else $error("changing write under protection");
  chk_boot_lock: assert property (s_start and $past(sec_q[1]) |-> flash_addr_out >= 16'h1000)
    else $error("boot cluster rewritten");
  chk_strobe_len: assert property (cnt_q <= OP_CYCLES) else $error("operation too long");
  chk_irq_mask: assert property (irq_out |-> msk_q != 4'h0) else $error("irq while all masked");
endmodule
bind fps_ctrl fps_ctrl_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (.*);

//--- test/fps_prog_model.sv
// programmer model: mode-select pulses, then the reset command on the serial line
// assumes the bench calls its tasks; outputs change just after rising edges
`timescale 1ns/1ns
module fps_prog_model (
  // clock
  input wire clk_in,
  // programming pins
  output reg flash_mode_pin_out,
  output reg prog_rx_out
);
  // pin high, serial line idle high
  initial
  begin
    flash_mode_pin_out = 1'b1;
    prog_rx_out = 1'b1;
  end
  // the pin level is held until changed, e.g. high through self-programming
  task pin(input logic v);
    @(posedge clk_in);
    flash_mode_pin_out <= v;
  endtask
  // it sends only the reset command, never erase-program-verify, so none falls in a boot swap
  // pulses always come before the command; len sets a fast or slow rate
  task send(input int n, input int len);
    repeat (n)
    begin
      @(posedge clk_in);
      flash_mode_pin_out <= 1'b0;
      @(posedge clk_in);
      flash_mode_pin_out <= 1'b1;
    end
    repeat (4) @(posedge clk_in);
    prog_rx_out <= 1'b0;
    repeat (len) @(posedge clk_in);
    prog_rx_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

//--- test/tb_top.sv
// bench for fps_ctrl: apb master, interrupt flags, programmer model
// assumes four-cycle operations so the run stays short
`timescale 1ns/1ns
module tb_top;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, saw = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, flags = 32'h0, masks = 32'h0, rv, msk = 32'h0;
  wire [31:0] prdata;
  wire [15:0] faddr;
  wire pready, pslverr, mpin, rx, fer, fwr, lnk, irq;
  int failures = 0, num_checks = 0;
  fps_ctrl #(.OP_CYCLES(4)) u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .flash_mode_pin_in(mpin), .prog_rx_in(rx), .irq_request_flags_in(flags),
    .irq_mask_flags_in(masks), .flash_erase_out(fer), .flash_write_out(fwr), .flash_addr_out(faddr),
    .link_clk_en_out(lnk), .irq_out(irq));
  fps_prog_model u_prog (.clk_in(clk_in), .flash_mode_pin_out(mpin), .prog_rx_out(rx));
  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  // remember any strobe seen during a command
  always @(posedge clk_in) if (fer || fwr) saw <= 1'b1;
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task final_report;
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1) @(posedge clk_in);
    rv = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, rv, e);
  endtask
  // one command: event bits, strobes, interrupt line, then clear
  task op(input logic [31:0] c, input logic [31:0] ev);
    saw = 1'b0;
    xfer(1'b1, 8'h00, c);
    rv = 32'h1;
    while (rv[1:0] !== 2'h0) xfer(1'b0, 8'h04, 32'h0);
    if (ev == 32'h4) chk("aborted", rv[4], 1'b1);
    chk("refused", rv[5], ev == 32'h2);
    rd_chk("events", 8'h08, ev);
    chk("strobes", saw, ev == 32'h1);
    chk("irq", irq, (ev & msk) != 32'h0);
    xfer(1'b1, 8'h08, 32'hF);
    @(posedge clk_in);
    chk("irq clr", irq, 1'b0);
  endtask
  task t_reset;
    rd_chk("stat", 8'h04, 32'h0);
    rd_chk("irq stat", 8'h08, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
  endtask
  task t_link;
    for (int v = 0; v < 4; v++)
    begin
      xfer(1'b1, 8'h00, 32'h40 | (v << 4));
      repeat (2) @(posedge clk_in);
      chk("link clk", lnk, v == 1 || v == 2);
    end
    xfer(1'b1, 8'h00, 32'h40);
    u_prog.send(2, 20);
    rd_chk("no lock", 8'h08, 32'h0);
    xfer(1'b1, 8'h00, 32'h50);
    u_prog.send(2, 20);
    rd_chk("locked", 8'h08, 32'h8);
    xfer(1'b0, 8'h18, 32'h0);
    chk("baud", rv >= 18 && rv <= 22, 1'b1);
    xfer(1'b1, 8'h08, 32'hF);
  endtask
  // every command code and two invalid ones, with the done irq masked and not
  task t_cmds;
    xfer(1'b1, 8'h14, 32'h2000);
    for (int c = 0; c < 5; c++)
    begin
      msk = (c == 2) ? 32'h0 : 32'hF;
      xfer(1'b1, 8'h0C, msk);
      op(32'h1 | (c << 1), (c >= 1 && c <= 3) ? 32'h1 : 32'h2);
    end
  endtask
  task t_abort;
    xfer(1'b1, 8'h00, 32'h5);
    repeat (2) @(posedge clk_in);
    flags <= 32'h100;
    repeat (2) @(posedge clk_in);
    chk("stopped", fwr, 1'b0);
    flags <= 32'h0;
    rd_chk("abort ev", 8'h08, 32'h4);
    xfer(1'b1, 8'h08, 32'hF);
    flags <= 32'h1;
    op(32'h5, 32'h4);
    masks <= 32'hFFFFFFFF;
    op(32'h5, 32'h4);
    flags <= 32'h0;
    u_prog.pin(1'b0);
    op(32'h5, 32'h2);
    u_prog.pin(1'b1);
  endtask
  // protection is set-only, so this runs last
  task t_secure;
    xfer(1'b1, 8'h10, 32'h1);
    op(32'h3, 32'h2);
    op(32'h7, 32'h2);
    op(32'h5, 32'h2);
    op(32'hFFFF0005, 32'h1);
    xfer(1'b1, 8'h10, 32'h2);
    rd_chk("sec", 8'h10, 32'h3);
    xfer(1'b1, 8'h14, 32'h0FFF);
    op(32'hFFFF0005, 32'h2);
    xfer(1'b1, 8'h14, 32'h1000);
    op(32'hFFFF0005, 32'h1);
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset;
    t_link;
    t_cmds;
    t_abort;
    t_secure;
    final_report;
  end
  // watchdog, far beyond the expected run
  initial
  begin
    #2000000;
    failures++;
    final_report;
  end
endmodule
